//--- tb/pms_mcu_model.sv
// Purpose: Far-side sampler timing the output line
// Assumes: Offset halves are at most half the phase before
// Notes: Reports once per cycle of three or more phases at the next marker
`timescale 1ns/1ps
`default_nettype none
module pms_mcu_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_line,
    output logic [31:0] o_reports,
    output logic [31:0] o_nph,
    output logic [31:0] o_off,
    output logic [31:0] o_ref,
    output logic [31:0] o_ratio,
    output logic [31:0] o_avg
);
    int len;
    int prv;
    int r;
    int ph;
    int acc[5];
    logic last;
    logic half;
    logic sync;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            len = 0;
            prv = 0;
            ph = 0;
            half = 1'b0;
            sync = 1'b0;
            last = 1'b0;
            o_reports <= 32'h0;
        end else begin
            len++;
            if (i_line !== last) begin
                if (half) begin
                    acc[0] = prv + len;
                    ph = 1;
                    half = 1'b0;
                end else if (2 * len <= prv) begin
                    if (sync && ph > 2) begin
                        o_nph <= ph;
                        o_off <= acc[0];
                        o_ref <= acc[1];
                        r = ((acc[2] - acc[0]) << 8) / (acc[1] - acc[0]);
                        o_ratio <= r;
                        o_avg <= (o_ratio + 32'(r)) >> 1;
                        o_reports <= o_reports + 32'h1;
                    end
                    half = 1'b1;
                    sync = 1'b1;
                end else begin
                    if (ph < 5) acc[ph] = len;
                    ph++;
                end
                prv = len;
                len = 0;
            end
            last = i_line;
        end
    end
endmodule
`default_nettype wire

//--- tb/pms_seq_monitor.sv
// Purpose: Port checks for pms_seq
// Assumes: Every interval is a whole number of fast periods
// Notes: Bound after the module
`timescale 1ns/1ps
`default_nettype none
module pms_seq_monitor #(
    parameter int unsigned N_FAST_P = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [pms_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [2:0] o_phase_idx,
    input wire logic o_out,
    input wire logic o_out_oe
);
    import pms_pkg::*;
    logic [19:0] len_ff;
    logic prev_ff;
    logic seen_ff;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);
    // Interval length; sleep clears seen_ff so the interval cut short by the wake-up is not checked
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            len_ff <= 20'h0;
            prev_ff <= 1'b0;
            seen_ff <= 1'b0;
        end else begin
            prev_ff <= o_out;
            seen_ff <= o_out_oe && (seen_ff || o_out != prev_ff);
            len_ff <= (o_out != prev_ff) ? 20'h1 : len_ff + 20'h1;
        end
    end
    a_phase_bound: assert property (o_phase_idx <= 3'h4)
        else $error("phase index above four");
    a_phase_order: assert property ($changed(o_phase_idx) |-> o_phase_idx == 3'h0 ||
        o_phase_idx == $past(o_phase_idx) + 3'h1)
        else $error("phase order broken");
    a_offset_marker: assert property ((o_out_oe && o_phase_idx == 3'h0 && $past(o_phase_idx) != 3'h0)
        |-> ##[1:800] ($changed(o_out) && o_phase_idx == 3'h0))
        else $error("offset phase without second half");
    a_interval_grain: assert property ((o_out_oe && seen_ff && o_out != prev_ff)
        |-> len_ff % N_FAST_P == 0)
        else $error("interval not whole oscillator periods");
    a_sleep_quiet: assert property (!o_out_oe |-> !o_out)
        else $error("output active while floated");
    a_sleep_write: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
        s_axi_awaddr == CTRL_OFS && s_axi_wstrb[0] && !s_axi_wdata[CTRL_SLEEP_BIT]) |-> ##[1:4] !o_out_oe)
        else $error("sleep write did not float output");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("ready while response pending");
    a_write_resp: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule
bind pms_seq pms_seq_monitor #(.N_FAST_P(N_FAST_P)) u_mon (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .o_phase_idx(o_phase_idx), .o_out(o_out), .o_out_oe(o_out_oe)
);
`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench for pms_seq
// Assumes: Small N values keep cycles short
// Notes: Released line toggles every cycle, no pull
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import pms_pkg::*;
    localparam int NS = 8;
    localparam int NF = 2;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [7:0] level = 8'h03;
    logic flt = 1'b0;
    logic [1:0] resp;
    logic [31:0] data;
    int errors = 0;
    int total_checks = 0;
    wire logic awready, wready, bvalid, arready, rvalid, out, oe, line;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata, reps, nph, off, rf, ratio, avg;
    wire logic [2:0] phase;
    assign line = oe ? out : flt;
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) flt <= ~flt;
    pms_seq #(.N_SLOW_P(NS), .N_FAST_P(NF)) dut (
        .i_sys_clk(clk), .i_nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .i_meas_level(level),
        .o_phase_idx(phase), .o_out(out), .o_out_oe(oe));
    pms_mcu_model mcu (.i_clk(clk), .i_rst_n(nrst), .i_line(line), .o_reports(reps), .o_nph(nph),
        .o_off(off), .o_ref(rf), .o_ratio(ratio), .o_avg(avg));
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        `CHK(bvalid, 1'b1)
        resp = bresp;
        bready <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        `CHK(rvalid, 1'b1)
        resp = rresp;
        data = rdata;
        rready <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic await(input int k);
        int n;
        int s;
        n = 0;
        s = reps;
        while (reps < s + k && n < 20000) begin
            @(posedge clk);
            n++;
        end
        `CHK(n < 20000, 1'b1)
    endtask
    task automatic meas(output int len);
        logic s;
        s = out;
        len = 0;
        while (out === s && len < 5000) begin
            @(posedge clk);
            len++;
        end
        s = out;
        len = 0;
        while (out === s && len < 5000) begin
            @(posedge clk);
            len++;
        end
    endtask
    function automatic logic [31:0] exp_nph(input int m);
        case (m)
            1, 4, 9, 10, 11, 12: return 32'h3;
            5, 6: return 32'h4;
            default: return 32'h5;
        endcase
    endfunction
    task automatic t_regs();
        rd(CTRL_OFS);
        `CHK(data, 32'h40)
        rd(4'hc);
        `CHK({resp, data}, {RESP_SLVERR, 32'h0})
        wr(4'hc, 32'h1);
        `CHK(resp, RESP_SLVERR)
        wr(STAT_OFS, 32'hffff_ffff);
        `CHK(resp, RESP_OKAY)
        rd(STAT_OFS);
        `CHK(data[14], 1'b1)
        $display("test regs done");
    endtask
    task automatic t_modes();
        int c0;
        // Start just after a report so every write lands early in a cycle
        await(1);
        for (int m = 0; m < 16; m++) begin
            if (m == 3) continue;
            c0 = (m < 2) ? 2 : 12;
            wr(CTRL_OFS, 32'h50 | 32'(m));
            await(2);
            `CHK(nph, exp_nph(m))
            `CHK(off, NF * c0)
            `CHK(rf, NF * (c0 + 3))
            `CHK(ratio, 32'h100)
            `CHK(avg, 32'h100)
        end
        rd(CTRL_OFS);
        `CHK(data[6:0], 7'h5f)
        $display("test modes done");
    endtask
    task automatic t_speed();
        wr(CTRL_OFS, 32'h41);
        await(2);
        `CHK(off, NS * 2)
        `CHK(rf, NS * 5)
        wr(CTRL_OFS, 32'h50);
        await(1);
        `CHK({nph, off}, {32'h3, 32'(NS * 2)})
        await(1);
        `CHK({nph, off}, {32'h5, 32'(NF * 2)})
        $display("test speed done");
    endtask
    task automatic t_sleep();
        wr(CTRL_OFS, 32'h10);
        `CHK({oe, out}, 2'b00)
        wr(CTRL_OFS, 32'h50);
        `CHK(oe, 1'b1)
        await(3);
        `CHK({nph, off}, {32'h5, 32'(NF * 2)})
        $display("test sleep done");
    endtask
    task automatic t_cap_external_mux();
        int len;
        level <= 8'h05;
        for (int r = 0; r < 2; r++) begin
            wr(CTRL_OFS, 32'h53 | 32'(r << 5));
            repeat (8) meas(len);
            `CHK(len, NF * ((r == 1 ? 12 : 2) + 5))
            `CHK(phase, 3'h0)
        end
        $display("test cap_external_mux done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        t_regs();
        t_modes();
        t_speed();
        t_sleep();
        t_cap_external_mux();
        close_out();
    end
    // Whole run is well under 20k cycles; four times 20k is a hang
    initial begin
        #2000000;
        errors++;
        close_out();
    end
endmodule
`default_nettype wire

//--- verilog/pms_down_cnt.sv
// Purpose: Loadable down counter timing one output interval
// Assumes: Load value is at least one
// Notes: o_done is high while the count stands at zero
`timescale 1ns/1ps
`default_nettype none
module pms_down_cnt #(
    parameter int W = 20
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [W-1:0] i_value,
    output logic o_done
);
    logic [W-1:0] cnt_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= '0;
        end else if (i_load) begin
            cnt_ff <= i_value - {{(W-1){1'b0}}, 1'b1};
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign o_done = (cnt_ff == '0);
endmodule
`default_nettype wire

//--- verilog/pms_pkg.sv
// Purpose: Shared constants for the period-modulated phase sequencer
// Assumes: 40 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes: Durations are counted in system clock cycles
package pms_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int AXI_AW = 4;
    localparam int TMR_W = 20;

    // Register byte offsets
    localparam logic [AXI_AW-1:0] CTRL_OFS = 4'h0;
    localparam logic [AXI_AW-1:0] STAT_OFS = 4'h4;
    localparam logic [AXI_AW-1:0] CYC_OFS = 4'h8;

    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SPEED_BIT = 4;
    localparam int CTRL_RANGE_BIT = 5;
    localparam int CTRL_SLEEP_BIT = 6;
    localparam logic [6:0] CTRL_RST = 7'h40;

    // Status field positions
    localparam int STAT_PHASE_LSB = 0;
    localparam int STAT_COUNT_LSB = 4;
    localparam int STAT_MODE_LSB = 8;
    localparam int STAT_SPEED_BIT = 12;
    localparam int STAT_OUT_BIT = 13;
    localparam int STAT_RUN_BIT = 14;

    // Oscillator periods per phase
    localparam int unsigned N_SLOW = 1024;
    localparam int unsigned N_FAST = 128;

    // Constant part of each phase, in level units
    localparam logic [7:0] C0_SMALL = 8'h02;
    localparam logic [7:0] C0_LARGE = 8'h0c;

    // Phase counts per cycle
    localparam logic [2:0] PH_ONE = 3'h1;
    localparam logic [2:0] PH_THREE = 3'h3;
    localparam logic [2:0] PH_FOUR = 3'h4;
    localparam logic [2:0] PH_FIVE = 3'h5;

    typedef enum logic [3:0] {
        MODE_CAP_FIVE_SMALL, MODE_CAP_THREE_SMALL, MODE_CAP_FIVE_LARGE, MODE_CAP_EXTERNAL_MUX,
        MODE_CAP_THREE_VARIABLE, MODE_PLATINUM_4WIRE, MODE_NTC_SENSOR_4WIRE, MODE_PLATINUM_MULTI,
        MODE_NTC_SENSOR_MULTI, MODE_BRIDGE_VREF_WIDE, MODE_BRIDGE_VREF_NARROW, MODE_BRIDGE_IREF_WIDE,
        MODE_BRIDGE_IREF_NARROW, MODE_BRIDGE_RESISTORS_WIDE, MODE_BRIDGE_RESISTORS_NARROW,
        MODE_THREE_WIPER_SENSORS
    } pms_mode_t;

    typedef enum logic {
        SEQ_IDLE, SEQ_RUN
    } pms_seq_t;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- verilog/pms_seq.sv
// Purpose: Mode decode, phase sequencing and period-modulated output
// Assumes: i_meas_level is the measured quantity for the phase after the one shown on o_phase_idx
// Notes: Configuration comes from the control register over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module pms_seq
    import pms_pkg::*;
#(
    parameter int unsigned N_SLOW_P = pms_pkg::N_SLOW,
    parameter int unsigned N_FAST_P = pms_pkg::N_FAST
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [pms_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pms_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] i_meas_level,
    output logic [2:0] o_phase_idx,
    output logic o_out,
    output logic o_out_oe
);
    import pms_pkg::*;

    logic rst_meta_ff;
    logic rst_n_ff;
    logic [6:0] ctrl_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [AXI_AW-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    pms_seq_t seq_ff;
    pms_mode_t mode_ff;
    logic speed_ff;
    logic range_ff;
    logic [2:0] count_ff;
    logic half_ff;
    logic [15:0] cyc_ff;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_value;
    logic tmr_done;
    logic [2:0] nxt_count;
    logic [7:0] nxt_c0;
    logic [7:0] c0;
    logic [TMR_W-1:0] n_now;
    logic [TMR_W-1:0] n_nxt;
    logic sleep_on;
    logic wr_fire;
    logic wr_addr_ok;
    logic [31:0] rd_word;
    logic rd_err;
    logic cyc_end;
    logic cfg_take;

    localparam logic [TMR_W-1:0] N_SLOW_W = TMR_W'(N_SLOW_P);
    localparam logic [TMR_W-1:0] N_FAST_W = TMR_W'(N_FAST_P);

    // Reset release through two flops
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // AXI write: address and data taken in either order
    assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;

    // Write decode; status and cycle words ignore writes but answer OKAY
    always_comb begin
        if (awaddr_ff == CTRL_OFS) begin
            wr_addr_ok = 1'b1;
        end else if (awaddr_ff == STAT_OFS) begin
            wr_addr_ok = 1'b1;
        end else if (awaddr_ff == CYC_OFS) begin
            wr_addr_ok = 1'b1;
        end else begin
            wr_addr_ok = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_got_ff && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_got_ff && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_addr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
            end
        end
    end

    // Control register; only byte lane 0 holds bits
    always_ff @(posedge i_sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ctrl_ff <= CTRL_RST;
        end else if (wr_fire && awaddr_ff == CTRL_OFS && wstrb_ff[0]) begin
            ctrl_ff <= wdata_ff[6:0];
        end
    end

    // Read decode; unmapped words read as zero with an error response
    always_comb begin
        rd_word = 32'h0;
        rd_err = 1'b0;
        if (s_axi_araddr == CTRL_OFS) begin
            rd_word[6:0] = ctrl_ff;
        end else if (s_axi_araddr == STAT_OFS) begin
            rd_word[STAT_PHASE_LSB +: 3] = o_phase_idx;
            rd_word[STAT_COUNT_LSB +: 3] = count_ff;
            rd_word[STAT_MODE_LSB +: 4] = mode_ff;
            rd_word[STAT_SPEED_BIT] = speed_ff;
            rd_word[STAT_OUT_BIT] = o_out;
            rd_word[STAT_RUN_BIT] = (seq_ff == SEQ_RUN);
        end else if (s_axi_araddr == CYC_OFS) begin
            rd_word[15:0] = cyc_ff;
        end else begin
            rd_err = 1'b1;
        end
    end

    // AXI read
    always_ff @(posedge i_sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Mode decode of the pending configuration
    always_comb begin
        case (pms_mode_t'(ctrl_ff[CTRL_MODE_LSB +: 4]))
            MODE_CAP_FIVE_SMALL: nxt_count = PH_FIVE;
            MODE_CAP_THREE_SMALL: nxt_count = PH_THREE;
            MODE_CAP_FIVE_LARGE: nxt_count = PH_FIVE;
            MODE_CAP_EXTERNAL_MUX: nxt_count = PH_ONE;
            MODE_CAP_THREE_VARIABLE: nxt_count = PH_THREE;
            MODE_PLATINUM_4WIRE: nxt_count = PH_FOUR;
            MODE_NTC_SENSOR_4WIRE: nxt_count = PH_FOUR;
            MODE_PLATINUM_MULTI: nxt_count = PH_FIVE;
            MODE_NTC_SENSOR_MULTI: nxt_count = PH_FIVE;
            MODE_BRIDGE_VREF_WIDE: nxt_count = PH_THREE;
            MODE_BRIDGE_VREF_NARROW: nxt_count = PH_THREE;
            MODE_BRIDGE_IREF_WIDE: nxt_count = PH_THREE;
            MODE_BRIDGE_IREF_NARROW: nxt_count = PH_THREE;
            MODE_BRIDGE_RESISTORS_WIDE: nxt_count = PH_FIVE;
            MODE_BRIDGE_RESISTORS_NARROW: nxt_count = PH_FIVE;
            MODE_THREE_WIPER_SENSORS: nxt_count = PH_FIVE;
            default: nxt_count = PH_FIVE;
        endcase
        // Constant part follows the capacitance range
        case (pms_mode_t'(ctrl_ff[CTRL_MODE_LSB +: 4]))
            MODE_CAP_FIVE_SMALL, MODE_CAP_THREE_SMALL: nxt_c0 = C0_SMALL;
            MODE_CAP_EXTERNAL_MUX: nxt_c0 = ctrl_ff[CTRL_RANGE_BIT] ? C0_LARGE : C0_SMALL;
            default: nxt_c0 = C0_LARGE;
        endcase
    end

    assign c0 = range_ff ? C0_LARGE : C0_SMALL;
    assign n_now = speed_ff ? N_FAST_W : N_SLOW_W;
    assign n_nxt = ctrl_ff[CTRL_SPEED_BIT] ? N_FAST_W : N_SLOW_W;
    assign sleep_on = !ctrl_ff[CTRL_SLEEP_BIT];

    // Interval end that closes a cycle; mode 3 closes one at every interval
    assign cyc_end = tmr_done && (o_phase_idx == (count_ff - 3'h1));
    assign cfg_take = !sleep_on && (seq_ff == SEQ_IDLE || cyc_end);

    // Next interval length; the offset phase runs as two halves
    always_comb begin
        tmr_load = 1'b0;
        tmr_value = '0;
        if (seq_ff == SEQ_IDLE || cyc_end) begin
            tmr_load = !sleep_on;
            if (nxt_count == PH_ONE) begin
                tmr_value = TMR_W'(n_nxt * (nxt_c0 + i_meas_level));
            end else begin
                tmr_value = TMR_W'((n_nxt * nxt_c0) >> 1);
            end
        end else if (tmr_done) begin
            tmr_load = 1'b1;
            if (count_ff != PH_ONE && o_phase_idx == 3'h0 && !half_ff) begin
                tmr_value = TMR_W'((n_now * c0) >> 1);
            end else begin
                tmr_value = TMR_W'(n_now * (c0 + i_meas_level));
            end
        end
    end

    pms_down_cnt #(
        .W(TMR_W)
    ) u_tmr (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n_ff),
        .i_load(tmr_load),
        .i_value(tmr_value),
        .o_done(tmr_done)
    );

    // Output enable follows the sleep bit one edge later
    always_ff @(posedge i_sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            o_out_oe <= 1'b0;
        end else begin
            o_out_oe <= !sleep_on;
        end
    end

    // Configuration taken only at a cycle boundary, so no cycle mixes two setups
    always_ff @(posedge i_sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            mode_ff <= MODE_CAP_FIVE_SMALL;
            speed_ff <= 1'b0;
            range_ff <= 1'b0;
            count_ff <= PH_FIVE;
        end else if (cfg_take) begin
            mode_ff <= pms_mode_t'(ctrl_ff[CTRL_MODE_LSB +: 4]);
            speed_ff <= ctrl_ff[CTRL_SPEED_BIT];
            range_ff <= (nxt_c0 == C0_LARGE);
            count_ff <= nxt_count;
        end
    end

    // Completed cycles, wrapping
    always_ff @(posedge i_sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cyc_ff <= '0;
        end else if (seq_ff == SEQ_RUN && !sleep_on && cyc_end) begin
            cyc_ff <= cyc_ff + 16'h1;
        end
    end

    // Phase sequencer
    always_ff @(posedge i_sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            seq_ff <= SEQ_IDLE;
            half_ff <= 1'b0;
            o_phase_idx <= 3'h0;
            o_out <= 1'b0;
        end else begin
            case (seq_ff)
                SEQ_IDLE: begin
                    if (!sleep_on) begin
                        seq_ff <= SEQ_RUN;
                        o_phase_idx <= 3'h0;
                        half_ff <= 1'b0;
                        o_out <= 1'b1;
                    end
                end
                SEQ_RUN: begin
                    if (sleep_on) begin
                        // Powered down: output floats and the cycle restarts later
                        seq_ff <= SEQ_IDLE;
                        o_out <= 1'b0;
                    end else if (tmr_done) begin
                        o_out <= !o_out;
                        if (count_ff != PH_ONE && o_phase_idx == 3'h0 && !half_ff) begin
                            half_ff <= 1'b1;
                        end else if (cyc_end) begin
                            // Cycle end: new configuration starts with the offset phase
                            o_phase_idx <= 3'h0;
                            half_ff <= 1'b0;
                        end else begin
                            o_phase_idx <= o_phase_idx + 3'h1;
                        end
                    end
                end
                default: seq_ff <= SEQ_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire
